// [test_usb_irq_enable_ep0_control.sv]
// self-checking bench for the interrupt-enable and ep0 control bank
// assumes usb_host_model for events and a one-cycle register port
`timescale 1ns/1ps
module test_usb_irq_enable_ep0_control;
  typedef struct {
    logic [15:0] a;
    logic [7:0] w;
    logic [7:0] e;
  } row_s;
  localparam logic [6:0] SETUP = 7'h40;
  localparam logic [6:0] SDATA = 7'h20;
  localparam logic [6:0] IN_D = 7'h18;
  localparam logic [6:0] OUT_D = 7'h10;
  localparam logic [6:0] IN_S = 7'h1C;
  localparam logic [6:0] OUT_S = 7'h14;
  localparam logic [15:0] CS = usb_ctl_pkg::EP0_CS_ADDR;
  logic i_clock = 1'b0;
  logic i_resetn = 1'b0;
  logic [15:0] i_addr = 16'h0000;
  logic [7:0] i_wdata = 8'h00;
  logic i_write = 1'b0;
  logic i_read = 1'b0;
  logic [7:0] o_rdata;
  logic o_usb_irq;
  logic [7:0] rv;
  usb_ctl_pkg::sie_event_s i_event;
  usb_ctl_pkg::handshake_e o_handshake;
  usb_ctl_pkg::irq_req_s i_req = '0;
  usb_ctl_pkg::irq_req_s o_req_clear;
  int bad_count = 0;
  int checks = 0;
  logic [15:0] ra [4] = '{16'hC7AC, 16'hC7AD, 16'hC7AE, 16'hC7B4};
  row_s rows [5] = '{'{16'hC7AC, 8'h2A, 8'h2A}, '{16'hC7AD, 8'h15, 8'h15},
    '{16'hC7AE, 8'h1F, 8'h1F}, '{16'hC7B0, 8'h55, 8'h00},
    '{16'hC7AC, 8'h01, 8'h01}};
  always #20 i_clock = ~i_clock;
  usb_host_model host (.i_clock(i_clock), .i_handshake(o_handshake),
    .o_event(i_event));
  usb_irq_enable_ep0_control dut (.i_clock(i_clock), .i_resetn(i_resetn),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read),
    .o_rdata(o_rdata), .i_event(i_event), .o_handshake(o_handshake),
    .i_req(i_req), .o_req_clear(o_req_clear), .o_usb_irq(o_usb_irq));
  task automatic chk(input string n, input logic [16:0] s, e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] w);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= w;
    i_write <= 1'b1;
    @(posedge i_clock);
    i_write <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_read <= 1'b1;
    @(posedge i_clock);
    i_read <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic cs(input logic [7:0] e);
    rd(CS, rv);
    chk("ep0 status", 17'(rv), 17'(e));
  endtask
  task automatic hs(input logic [6:0] ev, input logic [1:0] e);
    host.send(ev);
    chk("handshake", 17'(host.hs_seen), 17'(e));
  endtask
  task automatic irq(input logic [16:0] r, input logic e);
    @(posedge i_clock);
    i_req <= r;
    #1 chk("irq", 17'(o_usb_irq), 17'(e));
  endtask
  task automatic clr(input logic [15:0] a, input logic [7:0] w,
    input logic [16:0] e);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= w;
    i_write <= 1'b1;
    #1 chk("req clear", o_req_clear, e);
    @(posedge i_clock);
    i_write <= 1'b0;
  endtask
  task automatic test_done;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    test_done;
  end
  initial begin
    repeat (6) @(posedge i_clock);
    i_resetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(ra[i], rv);
      chk("reset value", 17'(rv), 17'h00000);
    end
    for (int i = 0; i < 5; i++) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rv);
      chk("register", 17'(rv), 17'(rows[i].e));
    end
    irq({6'h02, 6'h00, 5'h00}, 1'b0);
    irq({6'h01, 6'h00, 5'h00}, 1'b1);
    irq({6'h00, 6'h02, 5'h00}, 1'b0);
    irq({6'h00, 6'h04, 5'h00}, 1'b1);
    irq({6'h00, 6'h00, 5'h10}, 1'b1);
    irq(17'h00000, 1'b0);
    // write then read with no gap between the strobes
    @(posedge i_clock);
    i_addr <= usb_ctl_pkg::IN_IEN_ADDR;
    i_wdata <= 8'h3F;
    i_write <= 1'b1;
    @(posedge i_clock);
    i_write <= 1'b0;
    i_read <= 1'b1;
    @(posedge i_clock);
    i_read <= 1'b0;
    #1 chk("back to back", 17'(o_rdata), 17'h0003F);
    clr(16'hC7A9, 8'h05, {6'h05, 6'h00, 5'h00});
    clr(16'hC7AA, 8'h2A, {6'h00, 6'h2A, 5'h00});
    clr(16'hC7AB, 8'h11, {6'h00, 6'h00, 5'h11});
    host.send(SETUP);
    cs(8'h02);
    host.send(SDATA);
    cs(8'h22);
    wr(CS, 8'h00);
    cs(8'h22);
    wr(CS, 8'h20);
    cs(8'h02);
    hs(IN_D, usb_ctl_pkg::HS_NAK);
    wr(usb_ctl_pkg::IN0_BC_ADDR, 8'h08);
    wr(usb_ctl_pkg::OUT0_BC_ADDR, 8'h00);
    cs(8'h0E);
    wr(CS, 8'h0C);
    cs(8'h0E);
    hs(OUT_D, usb_ctl_pkg::HS_ACK);
    wr(CS, 8'h10);
    hs(IN_D, usb_ctl_pkg::HS_STALL);
    hs(OUT_D, usb_ctl_pkg::HS_STALL);
    cs(8'h1F);
    hs(IN_S, usb_ctl_pkg::HS_STALL);
    host.send(SETUP);
    cs(8'h02);
    hs(IN_S, usb_ctl_pkg::HS_NAK);
    wr(CS, 8'h02);
    cs(8'h00);
    wr(CS, 8'h10);
    hs(IN_S, usb_ctl_pkg::HS_ACK);
    wr(CS, 8'h01);
    hs(OUT_S, usb_ctl_pkg::HS_STALL);
    test_done;
  end
endmodule // test_usb_irq_enable_ep0_control

// [usb_ctl_pkg.sv]
// constants and carrier types for the usb interrupt-enable / ep0 control bank
// assumes byte-wide register port with 16-bit addresses
package usb_ctl_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int NUM_EP = 6;
  localparam logic [15:0] IN_IEN_ADDR = 16'hC7AC;
  localparam logic [15:0] OUT_IEN_ADDR = 16'hC7AD;
  localparam logic [15:0] BUS_IEN_ADDR = 16'hC7AE;
  localparam logic [15:0] EP0_CS_ADDR = 16'hC7B4;
  localparam logic [15:0] IN0_BC_ADDR = 16'hC7B5;
  localparam logic [15:0] OUT0_BC_ADDR = 16'hC7C5;
  localparam logic [15:0] IN_IRQ_ADDR = 16'hC7A9;
  localparam logic [15:0] OUT_IRQ_ADDR = 16'hC7AA;
  localparam logic [15:0] BUS_IRQ_ADDR = 16'hC7AB;
  // ep0 control/status bit positions
  localparam int CS_CHG = 5;
  localparam int CS_DSTALL = 4;
  localparam int CS_OUTBSY = 3;
  localparam int CS_INBSY = 2;
  localparam int CS_HSNAK = 1;
  localparam int CS_STALL = 0;
  localparam logic [4:0] BUS_IEN_MASK = 5'h1F;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [5:0] ZERO_EP = 6'h00;
  // handshake answers to the serial engine
  typedef enum logic [1:0] {
    HS_NONE = 2'b00,
    HS_ACK = 2'b01,
    HS_NAK = 2'b10,
    HS_STALL = 2'b11
  } handshake_e;
  // control transfer phase
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_DATA = 2'b01,
    PH_STATUS = 2'b10
  } ctl_phase_e;
  // events from the serial interface engine
  typedef struct packed {
    logic setup_token;
    logic setup_data;
    logic ep0_token;
    logic token_is_in;
    logic status_stage;
    logic in0_sent;
    logic out0_rcvd;
  } sie_event_s;
  // request flags kept elsewhere
  typedef struct packed {
    logic [5:0] in_req;
    logic [5:0] out_req;
    logic [4:0] bus_req;
  } irq_req_s;
endpackage

// [usb_ep0_ctl.sv]
// ep0 control/status flags and handshake decision
// assumes one-cycle event pulses from a same-clock serial engine
`timescale 1ns/1ps
module usb_ep0_ctl (
  input wire logic i_clock,
  input wire logic i_resetn,
  // register side
  input wire logic i_cs_write,
  input wire logic [7:0] i_wdata,
  input wire logic i_in0_bc_write,
  input wire logic i_out0_bc_write,
  // engine side
  input wire usb_ctl_pkg::sie_event_s i_event,
  // state out
  output logic [7:0] o_cs,
  output usb_ctl_pkg::handshake_e o_handshake
);
  logic chg_r, dstall_r, outbsy_r, inbsy_r, hsnak_r, stall_r;
  logic stall_in_data;
  assign stall_in_data = i_event.ep0_token && !i_event.status_stage
    && dstall_r;
  // setup data packet sets; write of one clears; set wins
  always_ff @(posedge i_clock) begin
    if (!i_resetn) chg_r <= 1'b0;
    else if (i_event.setup_data) chg_r <= 1'b1;
    else if (i_cs_write && i_wdata[usb_ctl_pkg::CS_CHG]) chg_r <= 1'b0;
  end
  always_ff @(posedge i_clock) begin
    if (!i_resetn) dstall_r <= 1'b0;
    else if (i_event.setup_token) dstall_r <= 1'b0;
    else if (i_cs_write && i_wdata[usb_ctl_pkg::CS_DSTALL]) dstall_r <= 1'b1;
  end
  // buffer ownership flags
  always_ff @(posedge i_clock) begin
    if (!i_resetn) outbsy_r <= 1'b0;
    else if (i_event.setup_token) outbsy_r <= 1'b0;
    else if (i_out0_bc_write) outbsy_r <= 1'b1;
    else if (i_event.out0_rcvd) outbsy_r <= 1'b0;
  end
  always_ff @(posedge i_clock) begin
    if (!i_resetn) inbsy_r <= 1'b0;
    else if (i_event.setup_token) inbsy_r <= 1'b0;
    else if (i_in0_bc_write) inbsy_r <= 1'b1;
    else if (i_event.in0_sent) inbsy_r <= 1'b0;
  end
  always_ff @(posedge i_clock) begin
    if (!i_resetn) hsnak_r <= 1'b0;
    else if (i_event.setup_token) hsnak_r <= 1'b1;
    else if (i_cs_write && i_wdata[usb_ctl_pkg::CS_HSNAK]) hsnak_r <= 1'b0;
  end
  always_ff @(posedge i_clock) begin
    if (!i_resetn) stall_r <= 1'b0;
    else if (i_event.setup_token) stall_r <= 1'b0;
    else if (stall_in_data) stall_r <= 1'b1;
    else if (i_cs_write && i_wdata[usb_ctl_pkg::CS_STALL]) stall_r <= 1'b1;
  end
  assign o_cs = {2'b00, chg_r, dstall_r, outbsy_r, inbsy_r, hsnak_r, stall_r};
  // handshake for an ep0 token in the data or status stage
  always_comb begin
    o_handshake = usb_ctl_pkg::HS_NONE;
    if (i_event.ep0_token && !i_event.setup_token) begin
      if (stall_r) o_handshake = usb_ctl_pkg::HS_STALL;
      // status stage with no excess data token follows hsnak and stall only
      else if (dstall_r && !i_event.status_stage)
        o_handshake = usb_ctl_pkg::HS_STALL;
      else if (i_event.status_stage) begin
        if (hsnak_r) o_handshake = usb_ctl_pkg::HS_NAK;
        else o_handshake = usb_ctl_pkg::HS_ACK;
      end else if (i_event.token_is_in ? inbsy_r : outbsy_r)
        o_handshake = usb_ctl_pkg::HS_ACK;
      else o_handshake = usb_ctl_pkg::HS_NAK;
    end
  end
  status_nak_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_event.ep0_token && i_event.status_stage && hsnak_r && !stall_r
    && !dstall_r && !i_event.setup_token |-> o_handshake == usb_ctl_pkg::HS_NAK)
    else $error("status stage not nakked");
  stall_set_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    stall_in_data && !i_event.setup_token |=> stall_r)
    else $error("ep0 stall not set after data stall");
  setup_clear_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_event.setup_token |=> !dstall_r && !stall_r && hsnak_r
    && !inbsy_r && !outbsy_r)
    else $error("setup token did not reset ep0 flags");
  status_ack_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_event.ep0_token && i_event.status_stage && !hsnak_r && !stall_r
    && !i_event.setup_token |-> o_handshake == usb_ctl_pkg::HS_ACK)
    else $error("status stage not acked");
  chg_set_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_event.setup_data |=> chg_r)
    else $error("setup change flag not set");
endmodule // usb_ep0_ctl

// [usb_host_model.sv]
// host side model: drives serial engine event pulses into the bank
// assumes the bank clock and a same-cycle combinational handshake
`timescale 1ns/1ps
module usb_host_model (
  // clock
  input wire logic i_clock,
  // answer from the bank
  input wire usb_ctl_pkg::handshake_e i_handshake,
  // token and packet events
  output usb_ctl_pkg::sie_event_s o_event
);
  logic [1:0] hs_seen;
  initial o_event = '0;
  // one-cycle event; handshake caught inside the token cycle
  task automatic send(input logic [6:0] ev);
    @(posedge i_clock);
    o_event <= ev;
    #1 hs_seen = i_handshake;
    @(posedge i_clock);
    o_event <= '0;
  endtask
endmodule // usb_host_model

// [usb_irq_enable_ep0_control.sv]
// interrupt enable registers and ep0 control/status bank
// assumes byte register port, same-clock serial engine and request flags
`timescale 1ns/1ps
// Summary of operation
// - in-endpoint enables bits 5:0 let each in request reach cpu
// - out-endpoint enables bits 5:0 let each out request reach cpu
// - bus enables reset4 suspend3 setup2 sof1 setupdata0; 7:5 zero
// - setup data packet sets setup-changed flag bit 5
// - writing one clears setup-changed; zero leaves it
// - data-stage stall bit stalls every data-stage in or out token
// - data-stage stall sets ep0 stall when a data-stage token arrives, status stage then stalled
// - data-stage stall cleared by setup token, set by writing one
// - proper status stage answered per status nak and stall bits
// - out busy read-only, cleared by setup, set by out count write
// - out busy one means controller owns ep0 out buffer
// - in busy read-only, cleared by setup, set by in count write
// - in busy one means controller owns ep0 in buffer
// - status nak bit naks every status-stage packet while ep0 stall is clear
// - status nak set by setup token, cleared by writing one
// - ep0 stall bit stalls data and handshake phase tokens
// - ep0 stall cleared by setup token, set by writing one
// - request flags cleared by writing one to their bit
module usb_irq_enable_ep0_control (
  input wire logic i_clock,
  input wire logic i_resetn,
  // register port
  input wire logic [usb_ctl_pkg::ADDR_W-1:0] i_addr,
  input wire logic [usb_ctl_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output logic [usb_ctl_pkg::DATA_W-1:0] o_rdata,
  // serial engine
  input wire usb_ctl_pkg::sie_event_s i_event,
  output usb_ctl_pkg::handshake_e o_handshake,
  // request flags from the flag registers
  input wire usb_ctl_pkg::irq_req_s i_req,
  // flag clear strobes, write-one-to-clear
  output usb_ctl_pkg::irq_req_s o_req_clear,
  // combined request to the processor
  output logic o_usb_irq
);
  logic [5:0] in_ien_r, out_ien_r;
  logic [4:0] bus_ien_r;
  logic [7:0] cs;
  logic [7:0] rdata_r;
  function automatic logic hit(input logic [15:0] a);
    hit = i_write && (i_addr == a);
  endfunction
  always_ff @(posedge i_clock) begin
    if (!i_resetn) in_ien_r <= usb_ctl_pkg::ZERO_EP;
    else if (hit(usb_ctl_pkg::IN_IEN_ADDR)) in_ien_r <= i_wdata[5:0];
  end
  always_ff @(posedge i_clock) begin
    if (!i_resetn) out_ien_r <= usb_ctl_pkg::ZERO_EP;
    else if (hit(usb_ctl_pkg::OUT_IEN_ADDR)) out_ien_r <= i_wdata[5:0];
  end
  // upper bits not stored, always read zero
  always_ff @(posedge i_clock) begin
    if (!i_resetn) bus_ien_r <= 5'h00;
    else if (hit(usb_ctl_pkg::BUS_IEN_ADDR))
      bus_ien_r <= i_wdata[4:0] & usb_ctl_pkg::BUS_IEN_MASK;
  end
  usb_ep0_ctl u_ep0 (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_cs_write(hit(usb_ctl_pkg::EP0_CS_ADDR)),
    .i_wdata(i_wdata),
    .i_in0_bc_write(hit(usb_ctl_pkg::IN0_BC_ADDR)),
    .i_out0_bc_write(hit(usb_ctl_pkg::OUT0_BC_ADDR)),
    .i_event(i_event),
    .o_cs(cs),
    .o_handshake(o_handshake)
  );
  // write-one-to-clear strobes for request flags
  always_comb begin
    o_req_clear.in_req = hit(usb_ctl_pkg::IN_IRQ_ADDR) ? i_wdata[5:0]
      : usb_ctl_pkg::ZERO_EP;
    o_req_clear.out_req = hit(usb_ctl_pkg::OUT_IRQ_ADDR) ? i_wdata[5:0]
      : usb_ctl_pkg::ZERO_EP;
    o_req_clear.bus_req = hit(usb_ctl_pkg::BUS_IRQ_ADDR) ? i_wdata[4:0]
      : 5'h00;
  end
  assign o_usb_irq = |(i_req.in_req & in_ien_r) | |(i_req.out_req & out_ien_r)
    | |(i_req.bus_req & bus_ien_r);
  always_ff @(posedge i_clock) begin
    if (!i_resetn) rdata_r <= usb_ctl_pkg::ZERO_BYTE;
    else if (i_read) begin
      unique case (i_addr)
        usb_ctl_pkg::IN_IEN_ADDR: rdata_r <= {2'b00, in_ien_r};
        usb_ctl_pkg::OUT_IEN_ADDR: rdata_r <= {2'b00, out_ien_r};
        usb_ctl_pkg::BUS_IEN_ADDR: rdata_r <= {3'b000, bus_ien_r};
        usb_ctl_pkg::EP0_CS_ADDR: rdata_r <= cs;
        default: rdata_r <= usb_ctl_pkg::ZERO_BYTE;
      endcase
    end else rdata_r <= usb_ctl_pkg::ZERO_BYTE;
  end
  assign o_rdata = rdata_r;
  irq_gate_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    o_usb_irq |-> (|(i_req.in_req & in_ien_r)) || (|(i_req.out_req &
    out_ien_r)) || (|(i_req.bus_req & bus_ien_r)))
    else $error("irq without enabled request");
  in_ien_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_write && i_addr == usb_ctl_pkg::IN_IEN_ADDR ##1 i_read
    && i_addr == usb_ctl_pkg::IN_IEN_ADDR && !i_write
    |=> o_rdata[5:0] == $past(i_wdata[5:0], 2))
    else $error("in enable readback wrong");
  bus_ien_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_read && i_addr == usb_ctl_pkg::BUS_IEN_ADDR |=> o_rdata[7:5] == 3'b000)
    else $error("bus enable upper bits nonzero");
  hs_stall_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_event.ep0_token && !i_event.setup_token && cs[usb_ctl_pkg::CS_STALL]
    |-> o_handshake == usb_ctl_pkg::HS_STALL)
    else $error("ep0 stall not honoured");
  chg_clear_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_write && i_addr == usb_ctl_pkg::EP0_CS_ADDR
    && i_wdata[usb_ctl_pkg::CS_CHG] && !i_event.setup_data
    |=> !cs[usb_ctl_pkg::CS_CHG])
    else $error("setup change not cleared");
  obsy_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_write && i_addr == usb_ctl_pkg::OUT0_BC_ADDR && !i_event.setup_token
    |=> cs[usb_ctl_pkg::CS_OUTBSY])
    else $error("out busy not set");
  setup_c: cover property (@(posedge i_clock) i_event.setup_token);
  stall_c: cover property (@(posedge i_clock)
    o_handshake == usb_ctl_pkg::HS_STALL);
  irq_c: cover property (@(posedge i_clock) o_usb_irq);
endmodule // usb_irq_enable_ep0_control
